// ---- logic/prcn_top.sv ----
// pin remapper with change detector and register port
`timescale 1ns/100ps
module prcn_top
  import prcn_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire prcn_addr_t reg_addr,
  input wire prcn_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output prcn_word_t reg_rdata,
  input wire prcn_chg_vec_t chg_pin,
  output prcn_chg_vec_t pullup_en,
  output prcn_chg_vec_t pulldown_en,
  output logic chg_irq,
  output logic chg_wake,
  input wire logic [`PRCN_NRP-1:0] rp_pin_in,
  output logic [`PRCN_NRPIO-1:0] rp_pin_out,
  output logic [`PRCN_NRPIO-1:0] rp_pin_oe_n,
  input wire logic [`PRCN_NPOUT-1:0] periph_out,
  output logic [`PRCN_NPIN-1:0] periph_in,
  input wire logic [`PRCN_NRPIO-1:0] special_en,
  input wire logic [`PRCN_NRPIO-1:0] special_out,
  input wire logic [`PRCN_NRPIO-1:0] pmp_en,
  input wire logic [`PRCN_NRPIO-1:0] pmp_out
);
  localparam int CHGB = `PRCN_CHG_WORDS * `PRCN_DW;
  localparam int RPB = `PRCN_RP_WORDS * `PRCN_DW;

  // pulls one 6-bit selector field out of a bus word
  function automatic prcn_sel_t fld_get(input prcn_word_t w, input int f);
    fld_get = w[f*`PRCN_FLD +: `PRCN_SELW];
  endfunction : fld_get

  // true when the address falls in word i of a bank starting at base
  function automatic logic hit_word(input prcn_addr_t a, input prcn_addr_t base,
                                    input int i);
    hit_word = (a == base + prcn_addr_t'(i));
  endfunction : hit_word

  prcn_chg_if cif ();

  // register state
  logic [CHGB-1:0] chg_en_q, chg_en_d;
  logic [CHGB-1:0] pu_q, pu_d;
  logic [CHGB-1:0] pd_q, pd_d;
  logic [RPB-1:0] dir_q, dir_d;
  logic [`PRCN_NRPIO-1:0] lat_q, lat_d;
  logic [RPB-1:0] ana_q, ana_d;
  prcn_sel_t [`PRCN_NPIN-1:0] imap_q, imap_d;
  prcn_sel_t [`PRCN_NRPIO-1:0] omap_q, omap_d;
  logic lock_q, lock_d;
  logic armed_q, armed_d;
  logic clr_q, clr_d;
  prcn_word_t rdata_q, rdata_d;

  // pin synchroniser and registered pin-side outputs
  logic [`PRCN_NRP-1:0] rp_meta_q, rp_sync_q;
  logic [`PRCN_NPIN-1:0] pin_q, pin_d;
  logic [`PRCN_NRPIO-1:0] out_q, out_d;
  logic [`PRCN_NRPIO-1:0] oe_n_q, oe_n_d;

  // zero-padded copies so each bank word is a plain part-select, no silent cut
  logic [CHGB-1:0] lvl_ext;
  logic [RPB-1:0] port_ext;

  prcn_chg_det u_chg (
    .mclk(mclk),
    .reset(reset),
    .chg_pin(chg_pin),
    .cif(cif.det)
  );

  assign cif.en = chg_en_q[`PRCN_NCHG-1:0];
  assign cif.clr = clr_q;

  // synced change pin levels and remappable pin levels for read back
  assign lvl_ext = {{(CHGB-`PRCN_NCHG){1'b0}}, cif.level};
  // analog pins read low
  assign port_ext = {{(RPB-`PRCN_NRP){1'b0}}, rp_sync_q} & ~ana_q;

  // register writes; the mapping selectors only move while unlocked
  always_comb begin
    chg_en_d = chg_en_q;
    pu_d = pu_q;
    pd_d = pd_q;
    dir_d = dir_q;
    lat_d = lat_q;
    ana_d = ana_q;
    imap_d = imap_q;
    omap_d = omap_q;
    lock_d = lock_q;
    armed_d = armed_q;
    clr_d = 1'b0;
    if (reg_wr) begin
      // any write other than the key disarms the unlock
      armed_d = 1'b0;
      for (int i = 0; i < `PRCN_CHG_WORDS; i++) begin
        if (hit_word(reg_addr, `PRCN_OFF_CHG_EN, i)) begin
          chg_en_d[i*`PRCN_DW +: `PRCN_DW] = reg_wdata;
        end
        if (hit_word(reg_addr, `PRCN_OFF_PULLUP, i)) begin
          pu_d[i*`PRCN_DW +: `PRCN_DW] = reg_wdata;
        end
        if (hit_word(reg_addr, `PRCN_OFF_PULLDN, i)) begin
          pd_d[i*`PRCN_DW +: `PRCN_DW] = reg_wdata;
        end
      end
      for (int i = 0; i < `PRCN_RP_WORDS; i++) begin
        if (hit_word(reg_addr, `PRCN_OFF_DIR, i)) begin
          dir_d[i*`PRCN_DW +: `PRCN_DW] = reg_wdata;
        end
        if (hit_word(reg_addr, `PRCN_OFF_ANA, i)) begin
          ana_d[i*`PRCN_DW +: `PRCN_DW] = reg_wdata;
        end
      end
      if (reg_addr == `PRCN_OFF_LAT) begin
        lat_d = reg_wdata;
      end
      if (reg_addr == `PRCN_OFF_CHG_STAT) begin
        // write one to clear; the detector lets a new change win
        clr_d = reg_wdata[`PRCN_BIT_FLAG];
      end
      if (reg_addr == `PRCN_OFF_KEY) begin
        armed_d = (reg_wdata == `PRCN_UNLOCK_KEY);
      end
      if (reg_addr == `PRCN_OFF_LOCK) begin
        // locking is free, unlocking needs the key written just before
        if (reg_wdata[`PRCN_BIT_LOCK]) begin
          lock_d = 1'b1;
        end else if (armed_q) begin
          lock_d = 1'b0;
        end
      end
      if (!lock_q) begin
        for (int i = 0; i < `PRCN_IMAP_WORDS; i++) begin
          for (int f = 0; f < `PRCN_FPW; f++) begin
            if (hit_word(reg_addr, `PRCN_OFF_IMAP, i) && (i*`PRCN_FPW + f < `PRCN_NPIN)) begin
              imap_d[i*`PRCN_FPW + f] = fld_get(reg_wdata, f);
            end
          end
        end
        for (int i = 0; i < `PRCN_OMAP_WORDS; i++) begin
          for (int f = 0; f < `PRCN_FPW; f++) begin
            if (hit_word(reg_addr, `PRCN_OFF_OMAP, i)) begin
              omap_d[i*`PRCN_FPW + f] = fld_get(reg_wdata, f);
            end
          end
        end
      end
    end
  end

  // read mux; data stand only in the cycle after the strobe
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      for (int i = 0; i < `PRCN_CHG_WORDS; i++) begin
        if (hit_word(reg_addr, `PRCN_OFF_CHG_EN, i)) begin
          rdata_d = chg_en_q[i*`PRCN_DW +: `PRCN_DW];
        end
        if (hit_word(reg_addr, `PRCN_OFF_PULLUP, i)) begin
          rdata_d = pu_q[i*`PRCN_DW +: `PRCN_DW];
        end
        if (hit_word(reg_addr, `PRCN_OFF_PULLDN, i)) begin
          rdata_d = pd_q[i*`PRCN_DW +: `PRCN_DW];
        end
        if (hit_word(reg_addr, `PRCN_OFF_CHG_PIN, i)) begin
          rdata_d = lvl_ext[i*`PRCN_DW +: `PRCN_DW];
        end
      end
      for (int i = 0; i < `PRCN_RP_WORDS; i++) begin
        if (hit_word(reg_addr, `PRCN_OFF_DIR, i)) begin
          rdata_d = dir_q[i*`PRCN_DW +: `PRCN_DW];
        end
        if (hit_word(reg_addr, `PRCN_OFF_ANA, i)) begin
          rdata_d = ana_q[i*`PRCN_DW +: `PRCN_DW];
        end
        if (hit_word(reg_addr, `PRCN_OFF_PORT, i)) begin
          rdata_d = port_ext[i*`PRCN_DW +: `PRCN_DW];
        end
      end
      for (int i = 0; i < `PRCN_IMAP_WORDS; i++) begin
        for (int f = 0; f < `PRCN_FPW; f++) begin
          if (hit_word(reg_addr, `PRCN_OFF_IMAP, i) && (i*`PRCN_FPW + f < `PRCN_NPIN)) begin
            rdata_d[f*`PRCN_FLD +: `PRCN_SELW] = imap_q[i*`PRCN_FPW + f];
          end
        end
      end
      for (int i = 0; i < `PRCN_OMAP_WORDS; i++) begin
        for (int f = 0; f < `PRCN_FPW; f++) begin
          if (hit_word(reg_addr, `PRCN_OFF_OMAP, i)) begin
            rdata_d[f*`PRCN_FLD +: `PRCN_SELW] = omap_q[i*`PRCN_FPW + f];
          end
        end
      end
      case (reg_addr)
        `PRCN_OFF_LAT: rdata_d = lat_q;
        `PRCN_OFF_CHG_STAT: rdata_d[`PRCN_BIT_FLAG] = cif.flag;
        `PRCN_OFF_LOCK: rdata_d[`PRCN_BIT_LOCK] = lock_q;
        default: rdata_d = rdata_d;
      endcase
    end
  end

  // remapped inputs: selector beyond the pin set or analog pin gives zero
  always_comb begin
    for (int k = 0; k < `PRCN_NPIN; k++) begin
      pin_d[k] = 1'b0;
      if (imap_q[k] < `PRCN_NRP_SEL) begin
        pin_d[k] = rp_sync_q[imap_q[k]] & ~ana_q[imap_q[k]];
      end
    end
  end

  // output owner per pin: special, then remapped, then parallel port, then latch
  // only pins below 32 have a driver at all; the rest are input only
  generate
    for (genvar p = 0; p < `PRCN_NRPIO; p++) begin : g_pin
      logic remap;
      assign remap = (omap_q[p] != `PRCN_SEL_NULL);
      always_comb begin
        if (special_en[p]) begin
          out_d[p] = special_out[p];
          oe_n_d[p] = 1'b0;
        end else if (remap) begin
          // remapped output still obeys the direction bit
          out_d[p] = periph_out[omap_q[p]];
          oe_n_d[p] = dir_q[p];
        end else if (pmp_en[p]) begin
          out_d[p] = pmp_out[p];
          oe_n_d[p] = 1'b0;
        end else begin
          // input mappings never touch the driver
          out_d[p] = lat_q[p];
          oe_n_d[p] = dir_q[p];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      chg_en_q <= '0;
      pu_q <= '0;
      pd_q <= '0;
      dir_q <= '1;
      lat_q <= '0;
      ana_q <= '0;
      imap_q <= {`PRCN_NPIN{`PRCN_SEL_NONE}};
      omap_q <= {`PRCN_NRPIO{`PRCN_SEL_NULL}};
      lock_q <= 1'b0;
      armed_q <= 1'b0;
      clr_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      chg_en_q <= chg_en_d;
      pu_q <= pu_d;
      pd_q <= pd_d;
      dir_q <= dir_d;
      lat_q <= lat_d;
      ana_q <= ana_d;
      imap_q <= imap_d;
      omap_q <= omap_d;
      lock_q <= lock_d;
      armed_q <= armed_d;
      clr_q <= clr_d;
      rdata_q <= rdata_d;
    end
  end

  // pin path registers; first stage feeds only the second
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rp_meta_q <= '0;
      rp_sync_q <= '0;
      pin_q <= '0;
      out_q <= '0;
      oe_n_q <= '1;
    end else begin
      rp_meta_q <= rp_pin_in;
      rp_sync_q <= rp_meta_q;
      pin_q <= pin_d;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign reg_rdata = rdata_q;
  // only digital functions ride the map; change inputs keep their own pins
  assign periph_in = pin_q;
  assign rp_pin_out = out_q;
  assign rp_pin_oe_n = oe_n_q;
  // software keeps pull-ups off on output pins; hardware does not police it
  assign pullup_en = pu_q[`PRCN_NCHG-1:0];
  assign pulldown_en = pd_q[`PRCN_NCHG-1:0];
  assign chg_irq = cif.flag;
  assign chg_wake = cif.wake;
endmodule : prcn_top

// ---- logic/prcn_cfg.svh ----
// constants for the pin remapper and input change detector
`ifndef PRCN_CFG_SVH
`define PRCN_CFG_SVH

`define PRCN_NCHG 81
`define PRCN_NRP 46
`define PRCN_NRPIO 32
`define PRCN_NPIN 36
`define PRCN_NPOUT 64
`define PRCN_SELW 6
`define PRCN_AW 8
`define PRCN_DW 32
`define PRCN_FLD 8
`define PRCN_FPW 4
`define PRCN_NRP_SEL 6'h2E
`define PRCN_SEL_NONE 6'h3F
`define PRCN_SEL_NULL 6'h00
`define PRCN_UNLOCK_KEY 32'h0000A55A

`define PRCN_OFF_CHG_EN 8'h00
`define PRCN_OFF_PULLUP 8'h04
`define PRCN_OFF_PULLDN 8'h08
`define PRCN_OFF_CHG_STAT 8'h0C
`define PRCN_OFF_LOCK 8'h0D
`define PRCN_OFF_KEY 8'h0E
`define PRCN_OFF_DIR 8'h10
`define PRCN_OFF_LAT 8'h14
`define PRCN_OFF_ANA 8'h16
`define PRCN_OFF_PORT 8'h18
`define PRCN_OFF_CHG_PIN 8'h1C
`define PRCN_OFF_IMAP 8'h20
`define PRCN_OFF_OMAP 8'h30

`define PRCN_CHG_WORDS 3
`define PRCN_RP_WORDS 2
`define PRCN_IMAP_WORDS 9
`define PRCN_OMAP_WORDS 8
`define PRCN_BIT_FLAG 0
`define PRCN_BIT_LOCK 0

`endif

// ---- logic/prcn_pkg.sv ----
// shared types for the pin remapper and change detector
`include "prcn_cfg.svh"
package prcn_pkg;
  typedef logic [`PRCN_SELW-1:0] prcn_sel_t;
  typedef logic [`PRCN_AW-1:0] prcn_addr_t;
  typedef logic [`PRCN_DW-1:0] prcn_word_t;
  typedef logic [`PRCN_NCHG-1:0] prcn_chg_vec_t;
endpackage : prcn_pkg

// ---- logic/prcn_chg_if.sv ----
// link between register block and change detector
`timescale 1ns/100ps
interface prcn_chg_if;
  import prcn_pkg::*;
  prcn_chg_vec_t en;
  logic clr;
  logic flag;
  logic wake;
  prcn_chg_vec_t level;
  modport det (input en, input clr, output flag, output wake, output level);
  modport ctl (output en, output clr, input flag, input wake, input level);
endinterface : prcn_chg_if

// ---- logic/prcn_chg_det.sv ----
// input change detector: synchroniser, last-value latch, sticky flag
`timescale 1ns/100ps
module prcn_chg_det
  import prcn_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire prcn_chg_vec_t chg_pin,
  prcn_chg_if.det cif
);
  prcn_chg_vec_t meta_q, sync_q, last_q;
  prcn_chg_vec_t sync_d, last_d;
  logic flag_q, flag_d;
  logic hit;

  // mismatch against the latched value, gated by the per-pin enable
  assign hit = |((sync_q ^ last_q) & cif.en);

  always_comb begin
    sync_d = meta_q;
    last_d = sync_q;
    flag_d = flag_q;
    if (cif.clr) begin
      flag_d = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (hit) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
      flag_q <= 1'b0;
    end else begin
      meta_q <= chg_pin;
      sync_q <= sync_d;
      last_q <= last_d;
      flag_q <= flag_d;
    end
  end

  assign cif.flag = flag_q;
  assign cif.level = sync_q;
  // clockless path: with mclk stopped the latch holds, so a raw difference wakes the core
  assign cif.wake = |((chg_pin ^ last_q) & cif.en);
endmodule : prcn_chg_det

// ---- test/prcn_assertions.sv ----
// concurrent checks on the remapper top ports
`timescale 1ns/100ps
`include "prcn_cfg.svh"
module prcn_chk
  import prcn_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire prcn_addr_t reg_addr,
  input wire prcn_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire prcn_word_t reg_rdata,
  input wire logic chg_irq,
  input wire logic chg_wake,
  input wire prcn_chg_vec_t pullup_en,
  input wire prcn_chg_vec_t pulldown_en,
  input wire logic [`PRCN_NRPIO-1:0] rp_pin_out,
  input wire logic [`PRCN_NRPIO-1:0] rp_pin_oe_n,
  input wire logic [`PRCN_NRPIO-1:0] special_en,
  input wire logic [`PRCN_NRPIO-1:0] special_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic clr;
  // flag clear write seen this cycle
  assign clr = reg_wr && reg_addr == `PRCN_OFF_CHG_STAT && reg_wdata[0];
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside read answer");
  a_unmapped_rd: assert property (reg_rd && reg_addr == 8'hFF |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  a_lock_rd: assert property (reg_rd && reg_addr == `PRCN_OFF_LOCK |=> reg_rdata[31:1] == '0)
    else $error("lock read has stray bits");
  a_pullup_wr: assert property (reg_wr && reg_addr == `PRCN_OFF_PULLUP
    |=> pullup_en[31:0] == $past(reg_wdata))
    else $error("pull-up bank not updated");
  a_pulldn_wr: assert property (reg_wr && reg_addr == 8'h0A
    |=> pulldown_en[80:64] == $past(reg_wdata[16:0]))
    else $error("pull-down bank not updated");
  a_special_val: assert property ((($past(special_en) & (rp_pin_out ^ $past(special_out))) == '0)
    && (($past(special_en) & rp_pin_oe_n) == '0))
    else $error("special output not winning");
  a_irq_hold: assert property (chg_irq && !clr && !$past(clr) |=> chg_irq)
    else $error("change flag dropped without clear");
  a_irq_cause: assert property ($rose(chg_irq) |-> $past(chg_wake) || $past(chg_wake, 2))
    else $error("change flag without pin change");
  a_irq_clear: assert property (clr && !chg_wake && !$past(chg_wake) && !$past(chg_wake, 2)
    |-> ##2 !chg_irq)
    else $error("change flag not cleared");
endmodule : prcn_chk

// ---- test/prcn_periph_model.sv ----
// far side model: peripherals and remappable pin wires
`timescale 1ns/100ps
`include "prcn_cfg.svh"
module prcn_periph_model
  import prcn_pkg::*;
(
  input wire logic [`PRCN_NRP-1:0] ext_lvl,
  input wire logic [`PRCN_NRPIO-1:0] rp_pin_out,
  input wire logic [`PRCN_NRPIO-1:0] rp_pin_oe_n,
  output logic [`PRCN_NRP-1:0] rp_pin_in,
  output logic [`PRCN_NPOUT-1:0] periph_out
);
  // odd function numbers high; function zero stays low as null
  assign periph_out = 64'hAAAAAAAAAAAAAAAA;
  // wire level: our drive where enabled, else the outside level
  assign rp_pin_in = {ext_lvl[45:32], (rp_pin_out & ~rp_pin_oe_n) | (ext_lvl[31:0] & rp_pin_oe_n)};
endmodule : prcn_periph_model

// ---- test/test_pin_remap_change_notify.sv ----
// self-checking bench for the remapper and change detector
`timescale 1ns/100ps
`include "prcn_cfg.svh"
module test_pin_remap_change_notify;
  import prcn_pkg::*;
  logic mclk, reset, reg_wr, reg_rd;
  prcn_addr_t reg_addr;
  prcn_word_t reg_wdata, reg_rdata;
  prcn_chg_vec_t chg_pin, pullup_en, pulldown_en;
  logic chg_irq, chg_wake;
  logic [45:0] rp_pin_in, ext_lvl;
  logic [31:0] rp_pin_out, rp_pin_oe_n, special_en, special_out, pmp_en, pmp_out;
  logic [63:0] periph_out;
  logic [35:0] periph_in;
  int mismatches, num_checks;
  prcn_top i_prcn_top (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chg_pin(chg_pin), .pullup_en(pullup_en), .pulldown_en(pulldown_en),
    .chg_irq(chg_irq), .chg_wake(chg_wake), .rp_pin_in(rp_pin_in),
    .rp_pin_out(rp_pin_out), .rp_pin_oe_n(rp_pin_oe_n), .periph_out(periph_out),
    .periph_in(periph_in), .special_en(special_en), .special_out(special_out),
    .pmp_en(pmp_en), .pmp_out(pmp_out));
  prcn_periph_model i_prcn_periph_model (.ext_lvl(ext_lvl), .rp_pin_out(rp_pin_out),
    .rp_pin_oe_n(rp_pin_oe_n), .rp_pin_in(rp_pin_in), .periph_out(periph_out));
  // free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [80:0] s, input logic [80:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr(input prcn_addr_t a, input prcn_word_t d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input prcn_addr_t a, output prcn_word_t d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // hang guard, far above the roughly 110 cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    print_verdict();
  end
  initial begin
    prcn_word_t d;
    {reg_wr, reg_rd, reg_addr, reg_wdata, chg_pin, ext_lvl} = '0;
    {special_en, special_out, pmp_en, pmp_out} = '0;
    reset = 1'b1;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    // reset state and unmapped space
    rd(`PRCN_OFF_DIR, d); chk(d, 32'hFFFFFFFF);
    rd(`PRCN_OFF_IMAP, d); chk(d, 32'h3F3F3F3F);
    rd(`PRCN_OFF_OMAP, d); chk(d, 32'h0);
    rd(8'hFF, d); chk(d, 32'h0);
    chk(rp_pin_oe_n, 32'hFFFFFFFF);
    chk(periph_in, 36'h0);
    wr(8'h38, 32'hFFFFFFFF);
    rd(8'h38, d); chk(d, 32'h0);
    $display("test reset done");
    // weak pulls; pull-up word 0 and pull-down word 2 reach their pins
    wr(`PRCN_OFF_PULLUP, 32'h0000A5A5);
    wr(8'h0A, 32'h00010001);
    tick(1);
    chk(pullup_en, 81'hA5A5);
    chk(pulldown_en, {17'h10001, 64'h0});
    $display("test pulls done");
    // change detect: disabled pin ignored, enabled pin sets flag
    wr(`PRCN_OFF_CHG_EN, 32'h8);
    @(posedge mclk);
    chg_pin[4] <= 1'b1;
    tick(5);
    chk(chg_irq, 1'b0);
    @(posedge mclk);
    chg_pin[3] <= 1'b1;
    #1;
    chk(chg_wake, 1'b1);
    tick(2);
    chk(chg_irq, 1'b0);
    tick(1);
    chk(chg_irq, 1'b1);
    tick(3);
    chk(chg_irq, 1'b1);
    rd(`PRCN_OFF_CHG_STAT, d); chk(d[0], 1'b1);
    wr(`PRCN_OFF_CHG_STAT, 32'h1);
    tick(1);
    chk(chg_irq, 1'b0);
    $display("test change done");
    // output priority on pin 0: special over remap over parallel port
    wr(`PRCN_OFF_DIR, 32'hFFFFFFFE);
    pmp_en[0] <= 1'b1;
    pmp_out[0] <= 1'b1;
    wr(`PRCN_OFF_OMAP, 32'h2);
    tick(3);
    chk({rp_pin_oe_n[0], rp_pin_out[0]}, 2'b00);
    special_en[0] <= 1'b1;
    special_out[0] <= 1'b1;
    tick(3);
    chk({rp_pin_oe_n[0], rp_pin_out[0]}, 2'b01);
    special_en[0] <= 1'b0;
    wr(`PRCN_OFF_OMAP, 32'h0);
    tick(3);
    chk({rp_pin_oe_n[0], rp_pin_out[0]}, 2'b01);
    $display("test output map done");
    // input map from input-only pin 33, then analog mode blocks it
    wr(`PRCN_OFF_IMAP, 32'h21);
    ext_lvl[33] <= 1'b1;
    tick(4);
    chk(periph_in[0], 1'b1);
    chk(rp_pin_oe_n[1], 1'b1);
    wr(8'h17, 32'h2);
    tick(4);
    chk(periph_in[0], 1'b0);
    $display("test input map done");
    // lock guards the map; only the key lets it open
    wr(`PRCN_OFF_OMAP, 32'h2);
    wr(`PRCN_OFF_LOCK, 32'h1);
    wr(`PRCN_OFF_OMAP, 32'h5);
    rd(`PRCN_OFF_OMAP, d); chk(d, 32'h2);
    wr(`PRCN_OFF_LOCK, 32'h0);
    rd(`PRCN_OFF_LOCK, d); chk(d, 32'h1);
    wr(`PRCN_OFF_KEY, `PRCN_UNLOCK_KEY);
    wr(`PRCN_OFF_LOCK, 32'h0);
    wr(`PRCN_OFF_OMAP, 32'h5);
    rd(`PRCN_OFF_OMAP, d); chk(d, 32'h5);
    $display("test lock done");
    // port read back: latch drives pin 4, remap drives pin 0
    wr(`PRCN_OFF_LAT, 32'h00000010);
    wr(`PRCN_OFF_DIR, 32'hFFFFFFEE);
    // software gap, plus the pin synchroniser stages before the port shows it
    tick(3);
    rd(`PRCN_OFF_PORT, d); chk(d, 32'h00000011);
    rd(8'h19, d); chk(d, 32'h0);
    rd(`PRCN_OFF_CHG_PIN, d); chk(d, 32'h00000018);
    $display("test port read done");
    print_verdict();
  end
endmodule : test_pin_remap_change_notify

bind prcn_top prcn_chk i_prcn_chk (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .chg_irq(chg_irq), .chg_wake(chg_wake), .pullup_en(pullup_en),
  .pulldown_en(pulldown_en), .rp_pin_out(rp_pin_out), .rp_pin_oe_n(rp_pin_oe_n),
  .special_en(special_en), .special_out(special_out));
